// ==== hdl/ihi_pkg.sv ====
// constants and carrier types for the isa host interface pin logic
// ---------------------------------------------------------------
// ---------------------------------------------------------------
package ihi_pkg;

   // ------------------------------------------------------------
   // widths
   // ------------------------------------------------------------
   localparam int IRQ_W = 8;
   localparam int ADDR_W = 10;
   localparam int SEL_W = 3;

   // ------------------------------------------------------------
   // address decode: 32-byte i/o window, data port at offset 0x10
   // ------------------------------------------------------------
   localparam int WIN_LSB = 5;
   localparam logic [4:0] DATA_PORT_OFS = 5'h10;

   // ------------------------------------------------------------
   // timing
   // ------------------------------------------------------------
   localparam int CLK_PERIOD_PS = 5000;
   localparam int RST_FILTER_NS = 800;
   // least time, so round up
   localparam int RST_FILTER_CYC = (RST_FILTER_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
   localparam int FILT_W = 8;
   localparam logic [FILT_W-1:0] FILT_LAST = FILT_W'(RST_FILTER_CYC - 1);
   localparam logic [FILT_W-1:0] FILT_ZERO = 8'h00;
   localparam logic [FILT_W-1:0] FILT_ONE = 8'h01;

   // ------------------------------------------------------------
   // reset values
   // ------------------------------------------------------------
   localparam logic [IRQ_W-1:0] IRQ_RST = 8'h00;
   localparam logic [ADDR_W-1:0] ADDR_RST = 10'h000;

   // ------------------------------------------------------------
   // carriers
   // ------------------------------------------------------------
   typedef struct packed {
      logic aen;
      logic ior_b;
      logic iow_b;
      logic [ADDR_W-1:0] sa;
   } ihi_cmd_t;

   localparam ihi_cmd_t CMD_IDLE = '{aen: 1'b1, ior_b: 1'b1, iow_b: 1'b1, sa: ADDR_RST};

   typedef struct packed {
      logic [IRQ_W-1:0] o;
      logic [IRQ_W-1:0] oe;
   } ihi_irq_drv_t;

   typedef enum logic [1:0] {
      RST_IDLE,
      RST_QUAL,
      RST_HELD
   } ihi_rst_state_t;

endpackage

// ==== hdl/ihi_top.sv ====
// isa host interface pin logic: irq pins, wait states, slot strap and iocs16b
`timescale 1ns/1ps
module ihi_top (
   input wire logic clk,
   input wire logic rst_b,
   // bus reset pin
   input wire logic rstdrv,
   // host command pins
   input wire logic aen,
   input wire logic ior_b,
   input wire logic iow_b,
   input wire logic [ihi_pkg::ADDR_W-1:0] sa,
   // i/o base from configuration
   input wire logic [ihi_pkg::ADDR_W-1:0] io_base,
   // core side
   input wire logic [ihi_pkg::SEL_W-1:0] irq_select,
   input wire logic irq_request,
   input wire logic access_busy,
   // irq request pins
   input wire logic [ihi_pkg::IRQ_W-1:0] irq_request_pins_i,
   output logic [ihi_pkg::IRQ_W-1:0] irq_request_pins_o,
   output logic [ihi_pkg::IRQ_W-1:0] irq_request_pins_oe,
   // iochrdy, open drain
   output logic iochrdy_o,
   output logic iochrdy_oe,
   // shared slot width strap / iocs16b pin
   input wire logic slot_width_strap_i,
   output logic slot_width_strap_o,
   output logic slot_width_strap_oe,
   // status towards the core
   output logic [ihi_pkg::IRQ_W-1:0] irq_line_monitor,
   output logic wide_slot_mode,
   output logic strap_valid,
   output logic io_access,
   output logic core_rst_b
);

   // ------------------------------------------------------------
   // functions
   // ------------------------------------------------------------
   function automatic logic win_hit(input logic aen_v,
                                    input logic [ihi_pkg::ADDR_W-1:0] a,
                                    input logic [ihi_pkg::ADDR_W-1:0] base);
      win_hit = !aen_v &&
                (a[ihi_pkg::ADDR_W-1:ihi_pkg::WIN_LSB] ==
                 base[ihi_pkg::ADDR_W-1:ihi_pkg::WIN_LSB]);
   endfunction

   function automatic logic [ihi_pkg::IRQ_W-1:0] one_hot(input logic [ihi_pkg::SEL_W-1:0] s);
      one_hot = ihi_pkg::IRQ_RST;
      one_hot[s] = 1'b1;
   endfunction

   // ------------------------------------------------------------
   // synchronisers
   // ------------------------------------------------------------
   logic rstdrv_s1_ff;
   logic rstdrv_s2_ff;
   logic [ihi_pkg::IRQ_W-1:0] irq_s1_ff;
   logic [ihi_pkg::IRQ_W-1:0] irq_s2_ff;
   logic strap_s1_ff;
   logic strap_s2_ff;
   ihi_pkg::ihi_cmd_t cmd_s1_ff;
   ihi_pkg::ihi_cmd_t cmd_s2_ff;

   // reset synchroniser only sees rst_b so a stuck bus reset cannot freeze it
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         rstdrv_s1_ff <= 1'b0;
         rstdrv_s2_ff <= 1'b0;
      end else begin
         rstdrv_s1_ff <= rstdrv;
         rstdrv_s2_ff <= rstdrv_s1_ff;
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_b) begin
         irq_s1_ff <= ihi_pkg::IRQ_RST;
         irq_s2_ff <= ihi_pkg::IRQ_RST;
      end else begin
         irq_s1_ff <= irq_request_pins_i;
         irq_s2_ff <= irq_s1_ff;
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_b) begin
         strap_s1_ff <= 1'b0;
         strap_s2_ff <= 1'b0;
         cmd_s1_ff <= ihi_pkg::CMD_IDLE;
         cmd_s2_ff <= ihi_pkg::CMD_IDLE;
      end else begin
         strap_s1_ff <= slot_width_strap_i;
         strap_s2_ff <= strap_s1_ff;
         cmd_s1_ff <= '{aen: aen, ior_b: ior_b, iow_b: iow_b, sa: sa};
         cmd_s2_ff <= cmd_s1_ff;
      end
   end

   // ------------------------------------------------------------
   // bus reset glitch filter
   // ------------------------------------------------------------
   ihi_pkg::ihi_rst_state_t rst_state_ff;
   ihi_pkg::ihi_rst_state_t nxt_rst_state;
   logic [ihi_pkg::FILT_W-1:0] filt_cnt_ff;
   logic [ihi_pkg::FILT_W-1:0] nxt_filt_cnt;
   logic rst_release;

   always_comb begin
      nxt_rst_state = rst_state_ff;
      nxt_filt_cnt = filt_cnt_ff;
      rst_release = 1'b0;
      case (rst_state_ff)
         ihi_pkg::RST_IDLE: begin
            if (rstdrv_s2_ff) begin
               nxt_rst_state = ihi_pkg::RST_QUAL;
               nxt_filt_cnt = ihi_pkg::FILT_ONE;
            end
         end
         ihi_pkg::RST_QUAL: begin
            // short pulse: drop back without touching anything
            if (!rstdrv_s2_ff) begin
               nxt_rst_state = ihi_pkg::RST_IDLE;
               nxt_filt_cnt = ihi_pkg::FILT_ZERO;
            end else if (filt_cnt_ff == ihi_pkg::FILT_LAST) begin
               nxt_rst_state = ihi_pkg::RST_HELD;
            end else begin
               nxt_filt_cnt = filt_cnt_ff + ihi_pkg::FILT_ONE;
            end
         end
         ihi_pkg::RST_HELD: begin
            if (!rstdrv_s2_ff) begin
               nxt_rst_state = ihi_pkg::RST_IDLE;
               nxt_filt_cnt = ihi_pkg::FILT_ZERO;
               rst_release = 1'b1;
            end
         end
         default: begin
            nxt_rst_state = ihi_pkg::RST_IDLE;
            nxt_filt_cnt = ihi_pkg::FILT_ZERO;
         end
      endcase
   end

   always_ff @(posedge clk) begin
      if (!rst_b) begin
         rst_state_ff <= ihi_pkg::RST_IDLE;
         filt_cnt_ff <= ihi_pkg::FILT_ZERO;
      end else begin
         rst_state_ff <= nxt_rst_state;
         filt_cnt_ff <= nxt_filt_cnt;
      end
   end

   // internal reset: board reset or a qualified bus reset
   logic bus_rst;
   logic core_rst_b_ff;
   assign bus_rst = (rst_state_ff == ihi_pkg::RST_HELD);

   always_ff @(posedge clk) begin
      if (!rst_b) begin
         core_rst_b_ff <= 1'b0;
      end else begin
         core_rst_b_ff <= !bus_rst;
      end
   end

   logic live;
   assign live = rst_b && core_rst_b_ff && !bus_rst;
   assign core_rst_b = core_rst_b_ff;

   // ------------------------------------------------------------
   // slot width strap
   // ------------------------------------------------------------
   logic wide_slot_ff;
   logic strap_valid_ff;

   // not cleared by bus reset: the strap is caught as that reset ends
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         wide_slot_ff <= 1'b0;
         strap_valid_ff <= 1'b0;
      end else if (rst_release) begin
         wide_slot_ff <= strap_s2_ff;
         strap_valid_ff <= 1'b1;
      end
   end

   assign wide_slot_mode = wide_slot_ff;
   assign strap_valid = strap_valid_ff;

   // ------------------------------------------------------------
   // iocs16b, open drain on the strap pin
   // ------------------------------------------------------------
   // raw pins on purpose: iocs16b must answer within the address phase
   logic data_port_hit;
   assign data_port_hit = win_hit(aen, sa, io_base) &&
                          (sa[ihi_pkg::WIN_LSB-1:0] == ihi_pkg::DATA_PORT_OFS);

   assign slot_width_strap_o = 1'b0;
   assign slot_width_strap_oe = live && strap_valid_ff && wide_slot_ff && data_port_hit;

   // ------------------------------------------------------------
   // wait states
   // ------------------------------------------------------------
   logic cmd_hit;
   assign cmd_hit = win_hit(cmd_s2_ff.aen, cmd_s2_ff.sa, io_base) &&
                    (!cmd_s2_ff.ior_b || !cmd_s2_ff.iow_b);

   assign io_access = live && cmd_hit;
   assign iochrdy_o = 1'b0;
   assign iochrdy_oe = live && cmd_hit && access_busy;

   // ------------------------------------------------------------
   // irq drive and monitor
   // ------------------------------------------------------------
   logic irq_level_ff;
   logic [ihi_pkg::SEL_W-1:0] irq_sel_ff;
   logic [ihi_pkg::IRQ_W-1:0] monitor_ff;

   always_ff @(posedge clk) begin
      if (!live) begin
         irq_level_ff <= 1'b0;
         irq_sel_ff <= irq_select;
      end else begin
         irq_level_ff <= irq_request;
         irq_sel_ff <= irq_select;
      end
   end

   // one line only; level follows request, all other bits float
   assign irq_request_pins_oe = one_hot(irq_sel_ff);
   assign irq_request_pins_o = irq_level_ff ? one_hot(irq_sel_ff) : ihi_pkg::IRQ_RST;

   always_ff @(posedge clk) begin
      if (!live) begin
         monitor_ff <= ihi_pkg::IRQ_RST;
      end else begin
         monitor_ff <= irq_s2_ff;
      end
   end

   assign irq_line_monitor = monitor_ff;

endmodule // ihi_top

// ==== verif/ihi_checker.sv ====
// concurrent checks on the isa host interface pin logic
`timescale 1ns/1ps
module ihi_checker (
   input wire logic clk,
   input wire logic rst_b,
   input wire logic rstdrv,
   input wire logic aen,
   input wire logic ior_b,
   input wire logic [9:0] sa,
   input wire logic [9:0] io_base,
   input wire logic [2:0] irq_select,
   input wire logic irq_request,
   input wire logic access_busy,
   input wire logic [7:0] irq_request_pins_i,
   input wire logic [7:0] irq_request_pins_o,
   input wire logic [7:0] irq_request_pins_oe,
   input wire logic iochrdy_oe,
   input wire logic slot_width_strap_i,
   input wire logic slot_width_strap_oe,
   input wire logic [7:0] irq_line_monitor,
   input wire logic wide_slot_mode,
   input wire logic strap_valid,
   input wire logic core_rst_b
);
   // ---------------------------------
   // bus reset high-time counter
   // ---------------------------------
   logic [7:0] hi_cnt_ff;
   always_ff @(posedge clk) begin
      if (!rst_b || !rstdrv) begin
         hi_cnt_ff <= 8'h00;
      end else if (hi_cnt_ff != 8'hff) begin
         hi_cnt_ff <= hi_cnt_ff + 8'h01;
      end
   end
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_b);
   // quiet window keeps the bus reset edges and the sync flush out of view
   sequence s_quiet; (!rstdrv && core_rst_b)[*5]; endsequence
   sequence s_hit; (core_rst_b && !aen && !ior_b && sa[9:5] == io_base[9:5])[*3]; endsequence
   property p_oe_one; $onehot(irq_request_pins_oe); endproperty
   property p_sel; irq_request_pins_oe == 8'h01 << $past(irq_select); endproperty
   property p_lvl; s_quiet |-> (|irq_request_pins_o) == $past(irq_request); endproperty
   property p_wait; s_hit ##0 access_busy |-> iochrdy_oe; endproperty
   property p_aen; aen[*3] |-> !iochrdy_oe; endproperty
   property p_cs16; s_quiet |-> slot_width_strap_oe == (!aen && strap_valid && wide_slot_mode
      && sa == {io_base[9:5], ihi_pkg::DATA_PORT_OFS}); endproperty
   property p_keep; $stable(rstdrv)[*8] |=> $stable(wide_slot_mode); endproperty
   property p_val; $rose(strap_valid) |-> wide_slot_mode == slot_width_strap_i; endproperty
   // sync, filter and reset flop put the fall 3 edges after the 160th high sample
   property p_filt; $fell(core_rst_b) |-> $past(hi_cnt_ff, 3) >= 8'ha0; endproperty
   property p_take; hi_cnt_ff == 8'hb4 |-> !core_rst_b; endproperty
   property p_mon; s_quiet |-> irq_line_monitor == $past(irq_request_pins_i, 3); endproperty
   a_oe_one: assert property (p_oe_one) else $error("irq enable not one-hot");
   a_sel: assert property (p_sel) else $error("wrong irq pin enabled");
   a_lvl: assert property (p_lvl) else $error("irq level wrong");
   a_wait: assert property (p_wait) else $error("no wait state");
   a_aen: assert property (p_aen) else $error("wait state with aen high");
   a_cs16: assert property (p_cs16) else $error("iocs16 decode wrong");
   a_keep: assert property (p_keep) else $error("strap moved off reset edge");
   a_val: assert property (p_val) else $error("strap latched wrong");
   a_filt: assert property (p_filt) else $error("short bus reset taken");
   a_take: assert property (p_take) else $error("long bus reset ignored");
   a_mon: assert property (p_mon) else $error("monitor wrong");
endmodule // ihi_checker

bind ihi_top ihi_checker u_chk (.clk(clk), .rst_b(rst_b), .rstdrv(rstdrv), .aen(aen),
   .ior_b(ior_b), .sa(sa), .io_base(io_base), .irq_select(irq_select),
   .irq_request(irq_request), .access_busy(access_busy),
   .irq_request_pins_i(irq_request_pins_i), .irq_request_pins_o(irq_request_pins_o),
   .irq_request_pins_oe(irq_request_pins_oe), .iochrdy_oe(iochrdy_oe),
   .slot_width_strap_i(slot_width_strap_i), .slot_width_strap_oe(slot_width_strap_oe),
   .irq_line_monitor(irq_line_monitor), .wide_slot_mode(wide_slot_mode),
   .strap_valid(strap_valid), .core_rst_b(core_rst_b));

// ==== verif/ihi_isa_host.sv ====
// host board model: irq line and shared strap pin levels
`timescale 1ns/1ps
module ihi_isa_host (
   input wire logic wide_slot,
   input wire logic [7:0] other_irq,
   input wire logic [7:0] irq_o,
   input wire logic [7:0] irq_oe,
   input wire logic strap_oe,
   output logic [7:0] irq_line,
   output logic strap_line
);
   // floating lines sit on the pull-up, another card pulls its own line low
   assign irq_line = (irq_oe & irq_o) | (~irq_oe & ~other_irq);
   // strong pull-up in a wide slot, weak pull-down in a narrow one
   assign strap_line = strap_oe ? 1'h0 : wide_slot;
endmodule // ihi_isa_host

// ==== verif/isa_host_interface_pins_test.sv ====
// self-checking bench for the isa host interface pin logic
`timescale 1ns/1ps
`define CHK(n, e, a) begin n_checks++; if ((a) !== (e)) begin err_total++; \
   $display("ERROR %s exp %h got %h", n, e, a); end end
module isa_host_interface_pins_test;
   localparam logic [9:0] BASE = 10'h300;
   logic clk = 1'h0;
   logic rst_b = 1'h0;
   logic rstdrv = 1'h0;
   logic aen = 1'h1;
   logic ior_b = 1'h1;
   logic iow_b = 1'h1;
   logic [9:0] sa = 10'h000;
   logic [2:0] irq_select = 3'h0;
   logic irq_request = 1'h0;
   logic access_busy = 1'h0;
   logic wide_slot = 1'h1;
   logic [7:0] other_irq = 8'h00;
   logic [7:0] irq_line, irq_o, irq_oe, mon;
   logic strap_line, strap_oe, rdy_oe, s16, valid, core_rst_b, seen_lo;
   logic rdy_o, cs_o, acc;
   int err_total = 0;
   int n_checks = 0;
   always #2.5 clk = ~clk;
   ihi_top dut (.clk(clk), .rst_b(rst_b), .rstdrv(rstdrv), .aen(aen), .ior_b(ior_b),
      .iow_b(iow_b), .sa(sa), .io_base(BASE), .irq_select(irq_select),
      .irq_request(irq_request), .access_busy(access_busy), .irq_request_pins_i(irq_line),
      .irq_request_pins_o(irq_o), .irq_request_pins_oe(irq_oe), .iochrdy_o(rdy_o),
      .iochrdy_oe(rdy_oe), .slot_width_strap_i(strap_line), .slot_width_strap_o(cs_o),
      .slot_width_strap_oe(strap_oe), .irq_line_monitor(mon), .wide_slot_mode(s16),
      .strap_valid(valid), .io_access(acc), .core_rst_b(core_rst_b));
   ihi_isa_host u_host (.wide_slot(wide_slot), .other_irq(other_irq), .irq_o(irq_o),
      .irq_oe(irq_oe), .strap_oe(strap_oe), .irq_line(irq_line), .strap_line(strap_line));
   // ---------------------------------
   // scenarios
   // ---------------------------------
   task automatic cyc(input int n);
      repeat (n) @(negedge clk);
   endtask
   task automatic bus_rst(input int n);
      seen_lo = 1'h0;
      rstdrv = 1'h1;
      repeat (n) begin
         @(negedge clk);
         if (core_rst_b !== 1'h1) seen_lo = 1'h1;
      end
      rstdrv = 1'h0;
      // the internal reset only drops 3 clocks after a minimum-length pulse
      repeat (8) begin
         @(negedge clk);
         if (core_rst_b !== 1'h1) seen_lo = 1'h1;
      end
   endtask
   task automatic t_strap(input logic w, input int n);
      wide_slot = w;
      bus_rst(n);
      `CHK("held", 1'h1, seen_lo)
      `CHK("valid", 1'h1, valid)
      `CHK("slot_width_strap", w, s16)
      `CHK("run", 1'h1, core_rst_b)
   endtask
   task automatic t_short;
      // strap flipped so a wrongly taken pulse would show up twice
      // one clock short of 800 ns
      wide_slot = 1'h0;
      bus_rst(159);
      `CHK("short", 1'h0, seen_lo)
      `CHK("kept", 1'h1, s16)
      wide_slot = 1'h1;
   endtask
   task automatic t_irq;
      for (int i = 0; i < 8; i++) begin
         irq_select = 3'(i);
         irq_request = i[0];
         other_irq = 8'h80 >> i;
         cyc(4);
         `CHK("oe", 8'h01 << i, irq_oe)
         `CHK("o", i[0] ? 8'h01 << i : 8'h00, irq_o)
         `CHK("mon", ~(8'h80 >> i) & ~(i[0] ? 8'h00 : 8'h01 << i), mon)
      end
      other_irq = 8'h00;
      irq_request = 1'h0;
   endtask
   task automatic t_wait;
      aen = 1'h0;
      ior_b = 1'h0;
      sa = BASE + 10'h003;
      access_busy = 1'h1;
      cyc(4);
      `CHK("wait", 1'h1, rdy_oe)
      `CHK("acc", 1'h1, acc)
      `CHK("rdy_lvl", 1'h0, rdy_o)
      access_busy = 1'h0;
      #1 `CHK("ready", 1'h0, rdy_oe)
      cyc(1);
      access_busy = 1'h1;
      aen = 1'h1;
      cyc(4);
      `CHK("aen", 1'h0, rdy_oe)
      `CHK("acc_aen", 1'h0, acc)
      aen = 1'h0;
      sa = BASE + 10'h020;
      cyc(4);
      `CHK("window", 1'h0, rdy_oe)
      sa = BASE + 10'h003;
      ior_b = 1'h1;
      iow_b = 1'h0;
      cyc(4);
      `CHK("wait_wr", 1'h1, rdy_oe)
      aen = 1'h1;
      iow_b = 1'h1;
      access_busy = 1'h0;
      cyc(4);
   endtask
   task automatic t_cs16(input logic e);
      sa = BASE + 10'h010;
      aen = 1'h0;
      #1 `CHK("cs16", e, strap_oe)
      `CHK("cs16_lvl", 1'h0, cs_o)
      cyc(1);
      aen = 1'h1;
      #1 `CHK("cs16_aen", 1'h0, strap_oe)
      cyc(1);
      sa = BASE + 10'h011;
      aen = 1'h0;
      #1 `CHK("cs16_ofs", 1'h0, strap_oe)
      cyc(1);
      aen = 1'h1;
      cyc(4);
   endtask
   task automatic conclude;
      $display("checks %0d errors %0d", n_checks, err_total);
      if (err_total == 0 && n_checks > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask
   initial begin
      cyc(8);
      rst_b = 1'h1;
      cyc(2);
      t_strap(1'h1, 200);
      t_irq;
      t_wait;
      t_cs16(1'h1);
      t_short;
      t_strap(1'h0, 160);
      t_cs16(1'h0);
      conclude;
   end
   // about 620 cycles (3.1 us) expected, so 10 us leaves ample margin
   initial begin
      #10000;
      err_total++;
      conclude;
   end
endmodule // isa_host_interface_pins_test
